/* File: dv/ssp_far_end.sv */
// Far-end serial slave model
`timescale 1ns/1ps
`default_nettype none
module ssp_far_end (
  // Serial pins seen from the far end
  input  wire logic sck,
  input  wire logic din,
  output logic      dout
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic       lsb = 1'b0;
  logic [3:0] cnt = 4'h8;
  initial dout = 1'b1;
  task automatic load(input logic [7:0] b, input logic l);
    tx = b;
    lsb = l;
    rx = 8'h00;
    cnt = 4'h0;
  endtask
  // Next bit out on the falling edge
  always @(negedge sck) begin
    if (cnt < 4'h8) begin
      dout <= lsb ? tx[0] : tx[7];
      tx  <= lsb ? tx >> 1 : tx << 1;
    end
  end
  // Sample on the rising edge, invert the line 100 ns after the last bit
  always @(posedge sck) begin
    if (cnt < 4'h8) begin
      rx  <= lsb ? {din, rx[7:1]} : {rx[6:0], din};
      cnt <= cnt + 4'h1;
    end
    if (cnt == 4'h7) dout <= #100 ~dout;
  end
endmodule
`default_nettype wire

/* File: dv/ssp_properties.sv */
// Checker on the serial port pins and register bus answers
`timescale 1ns/1ps
`default_nettype none
module ssp_props (
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Register bus answers
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [31:0]              s_axi_rdata,
  // Port C pins
  input wire logic [ssp_pkg::PC_W-1:0] pc_out,
  input wire logic [ssp_pkg::PC_W-1:0] pc_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       prev_sck;
  logic       prev_oe;
  logic [3:0] edge_cnt;
  always_ff @(posedge aclk) begin
    prev_sck <= pc_out[2];
    prev_oe  <= pc_oe[2];
  end
  // Rising clock edges since the last completed write
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
      edge_cnt <= 4'h0;
    end else if (prev_oe && pc_oe[2] && !prev_sck && pc_out[2]) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end
  sequence s_low_fast;
    ##1 pc_out[2];
  endsequence
  sequence s_low_slow;
    ##1 (!pc_out[2])[*7] ##1 pc_out[2];
  endsequence
  a_clk_half_rate: assert property (
    pc_oe[2] && $fell(pc_out[2]) |-> s_low_fast or s_low_slow)
    else $error("serial clock low phase has wrong length");
  a_eight_edges: assert property (edge_cnt <= 4'h8)
    else $error("more than eight clock edges in one byte");
  a_clk_parked: assert property (edge_cnt == 4'h8 |-> pc_out[2] || !pc_oe[2])
    else $error("serial clock left idle level after the byte");
  a_dout_on_fall: assert property (
    pc_oe == 3'h6 && $past(pc_oe) == 3'h6 && $changed(pc_out[1]) |-> $fell(pc_out[2]))
    else $error("data out changed away from a falling clock");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_b_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule
bind ssp_port ssp_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pc_out(pc_out), .pc_oe(pc_oe));
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the serial shift port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] A_CTRL = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2c;
  localparam logic [7:0] A_DATA = 8'h30;
  localparam logic [7:0] A_CPU  = 8'h34;
  localparam logic [7:0] A_PORT = 8'h38;
  localparam logic [7:0] A_DIR  = 8'h3c;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, far_dout;
  logic        ext_sck = 1'b1;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  pc_in, pc_out, pc_oe;
  int          num_errors = 0;
  int          n_checks = 0;
  always #20 aclk = ~aclk;
  assign pc_in = {pc_oe[2] ? pc_out[2] : ext_sck, pc_oe[1] ? pc_out[1] : 1'b1,
                  pc_oe[0] ? pc_out[0] : far_dout};
  ssp_port uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe(pc_oe), .transfer_irq(irq));
  ssp_far_end far (.sck(pc_in[2]), .din(pc_in[1]), .dout(far_dout));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [31:0] v;
    rd(a, v);
    check(what, v, {24'h00_0000, exp});
  endtask
  task automatic settle();
    repeat (3) @(negedge aclk);
  endtask
  task automatic wait_done();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(A_STAT, s);
      n++;
    end while (s[7] !== 1'b1 && n < 400);
  endtask
  task automatic t_reset();
    logic [31:0] v;
    rdc(A_CTRL, 8'h00, "control reset");
    rdc(A_STAT, 8'h00, "status reset");
    rdc(A_CPU, 8'h01, "cpu state reset");
    wr(A_STAT, 8'hc0);
    rdc(A_STAT, 8'h00, "status read only");
    rd(8'h04, v);
    check("unmapped response", 32'(resp), 32'h2);
    check("pins released", 32'(pc_oe), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_store();
    wr(A_DATA, 8'h5a);
    rdc(A_DATA, 8'h5a, "data storage");
    wr(A_DIR, 8'h07);
    wr(A_PORT, 8'h05);
    settle();
    check("gpio drive", 32'({pc_oe, pc_out}), 32'h3d);
    rdc(A_PORT, 8'h05, "gpio latch read");
    $display("test storage done");
  endtask
  task automatic t_xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] rx);
    far.load(rx, c[5]);
    wr(A_CTRL, c);
    wr(A_DATA, tx);
    check("master pin dirs", 32'(pc_oe), 32'h6);
    wait_done();
    rdc(A_STAT, 8'h80, "done flag");
    check("byte at far end", 32'(far.rx), 32'(tx));
    rdc(A_DATA, rx, "byte received");
    rdc(A_STAT, 8'h00, "done cleared");
    rdc(A_PORT, 8'h05, "latch while enabled");
    $display("test transfer done");
  endtask
  task automatic t_collide();
    int n;
    n = 0;
    wr(A_CPU, 8'h00);
    far.load(8'h96, 1'b0);
    wr(A_CTRL, 8'hd0);
    wr(A_DATA, 8'h3c);
    wr(A_DATA, 8'hff);
    check("irq on collision", 32'(irq), 32'h0);
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge aclk);
      n++;
    end
    check("irq on done", 32'(irq), 32'h1);
    wr(A_DATA, 8'h22);
    rdc(A_STAT, 8'hc0, "collision flag");
    rdc(A_DATA, 8'h96, "write while done");
    check("byte kept", 32'(far.rx), 32'h3c);
    rdc(A_STAT, 8'h00, "both flags cleared");
    settle();
    check("irq cleared", 32'(irq), 32'h0);
    $display("test collision done");
  endtask
  task automatic t_stop();
    wr(A_CPU, 8'h02);
    far.load(8'h5c, 1'b0);
    wr(A_DATA, 8'ha3);
    wait_done();
    settle();
    check("irq held in stop", 32'(irq), 32'h0);
    rdc(A_CTRL, 8'hd0, "enable kept in stop");
    wr(A_CPU, 8'h00);
    settle();
    check("irq after stop", 32'(irq), 32'h1);
    rdc(A_DATA, 8'h5c, "stop byte");
    $display("test stop done");
  endtask
  task automatic t_slave();
    wr(A_CTRL, 8'h40);
    far.load(8'h6e, 1'b0);
    wr(A_DATA, 8'hb1);
    check("slave pin dirs", 32'(pc_oe), 32'h2);
    repeat (18) begin
      repeat (8) @(posedge aclk);
      ext_sck <= ~ext_sck;
    end
    settle();
    check("slave byte out", 32'(far.rx), 32'hb1);
    rdc(A_STAT, 8'h80, "slave done");
    rdc(A_DATA, 8'h6e, "slave byte in");
    $display("test slave done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_store();
    t_xfer(8'h50, 8'ha5, 8'h3c);
    t_xfer(8'h71, 8'h4b, 8'hd2);
    t_collide();
    t_stop();
    t_slave();
    results();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire

/* File: hdl/ssp_pkg.sv */
// Shared constants and types for the simple serial shift port
// Overview of operation
// R1: Interrupt raised when enabled, transfer done and CPU mask bit clear.
// R2: In stop mode only slave requests pass; stop leaves flag and enable alone.
// R3: Port enable connects port C pins; clearing resets port control logic.
// R4: Shift order select set means LSB first, clear means MSB first.
// R5: Controller select drives clock pin out and starts clocks on data write.
// R6: Master clock is processor clock divided by 2, or by 16 when selected.
// R7: Master mode data write starts one full-duplex byte transfer.
// R8: Done flag sets on rising edge of the eighth serial clock.
// R9: While done flag is set, any ninth clock is blocked.
// R10: Status read with done set, then data access, clears done and collision.
// R11: Data writes ignored while done flag set until status is read.
// R12: Done flag is read-only; done and collision flags clear on reset.
// R13: Data access during transfer sets collision; transfer continues, write dropped.
// R14: Collision flag never raises an interrupt by itself.
// R15: Collision leaves the shifting byte unchanged.
// R16: With port disabled, data register is plain read/write storage.
// R17: Enabled port uses pin 0 as data in, 1 as data out, 2 as clock.
// R18: Direction bits do not steer pins when enabled; reads pick latch or pin.
// R19: Output bit changes on falling clock edge, input sampled on rising.
// R20: Each bit shifted out is replaced by the received bit.
// R21: Control bits 7..4 and 0; status done bit 7, collision bit 6.
package ssp_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PC_W     = 3;
  localparam int unsigned FAST_DIV = 2;
  localparam int unsigned SLOW_DIV = 16;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h0a;
  localparam logic [5:0] IDX_STAT = 6'h0b;
  localparam logic [5:0] IDX_DATA = 6'h0c;
  localparam logic [5:0] IDX_CPU  = 6'h0d;
  localparam logic [5:0] IDX_PORT = 6'h0e;
  localparam logic [5:0] IDX_DIR  = 6'h0f;

  localparam logic [7:0] CTRL_WMASK = 8'hf1;
  localparam logic [7:0] CPU_RST    = 8'h01;
  localparam logic [2:0] PIN_IDLE   = 3'h7;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;

  // Control register layout
  typedef struct packed {
    logic       irq_en;
    logic       enable;
    logic       lsb_first;
    logic       master;
    logic [2:0] rsvd;
    logic       rate_slow;
  } ssp_ctrl_t;

  // Status register layout
  typedef struct packed {
    logic       done;
    logic       collision;
    logic [5:0] rsvd;
  } ssp_stat_t;

  // CPU state register layout
  typedef struct packed {
    logic [5:0] rsvd;
    logic       stop;
    logic       irq_mask;
  } ssp_cpu_t;

endpackage

/* File: hdl/ssp_port.sv */
// Serial shift port with AXI4-Lite registers and port C pin sharing
`timescale 1ns/1ps
`default_nettype none
module ssp_port (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic [ssp_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ssp_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Port C pins 0..2
  input  wire logic [ssp_pkg::PC_W-1:0]    pc_in,
  output logic [ssp_pkg::PC_W-1:0]         pc_out,
  output logic [ssp_pkg::PC_W-1:0]         pc_oe,
  // Transfer interrupt request
  output logic                             transfer_irq
);

  // Register position of the n-th bit on the wire
  function automatic logic [2:0] bit_pos(input logic [2:0] n, input logic lsb);
    bit_pos = lsb ? n : ssp_pkg::LAST_BIT - n;
  endfunction

  function automatic logic [5:0] word_idx(input logic [ssp_pkg::ADDR_W-1:0] a);
    word_idx = a[7:2];
  endfunction

  // Registers
  ssp_pkg::ssp_ctrl_t          serial_control;
  logic [7:0]                  serial_data_shift;
  logic                        transfer_done_flag;
  logic                        collision_flag;
  ssp_pkg::ssp_cpu_t           cpu_state;
  logic [ssp_pkg::PC_W-1:0]    pc_latch;
  logic [ssp_pkg::PC_W-1:0]    port_c_direction;

  // Transfer state
  logic                        busy;
  logic [2:0]                  bit_cnt;
  logic                        sck_q;
  logic                        data_out_q;
  logic [2:0]                  rise_pipe;
  logic [2:0]                  rx_cnt;
  logic                        cap_e;
  logic                        armed;

  // Pin synchronisers
  logic [ssp_pkg::PC_W-1:0]    pc_meta;
  logic [ssp_pkg::PC_W-1:0]    pc_sync;
  logic                        sck_prev;

  // Bus holding state
  logic                        aw_got;
  logic                        w_got;
  logic [ssp_pkg::ADDR_W-1:0]  aw_addr_q;
  logic [7:0]                  w_data_q;
  logic                        w_lane0_q;

  // Combinational terms
  logic                        m_tick;
  logic                        master_on;
  logic                        slave_on;
  logic                        fall_e;
  logic                        rise_e;
  logic                        do_wr;
  logic                        rd_go;
  logic [5:0]                  wr_idx;
  logic [5:0]                  rd_idx;
  logic                        data_acc;
  logic                        data_wr;
  logic                        stat_rd;
  logic                        clear_seq;
  logic                        write_ok;
  logic                        start_m;
  logic                        done_set;
  ssp_pkg::ssp_stat_t          stat_view;
  logic [7:0]                  port_view;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;
  logic [1:0]                  next_bresp;
  logic [ssp_pkg::PC_W-1:0]    next_pc_out;
  logic [ssp_pkg::PC_W-1:0]    next_pc_oe;
  logic                        next_irq;

  ssp_rate_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (busy && master_on),
    .slow    (serial_control.rate_slow),
    .tick    (m_tick)
  );

  // Pin input synchronisers, clock pin idles high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_meta  <= ssp_pkg::PIN_IDLE;
      pc_sync  <= ssp_pkg::PIN_IDLE;
      sck_prev <= 1'b1;
    end else begin
      pc_meta  <= pc_in;
      pc_sync  <= pc_meta;
      sck_prev <= pc_sync[2];
    end
  end

  // Clock edge sources
  always_comb begin
    master_on = serial_control.enable && serial_control.master; // R5
    slave_on  = serial_control.enable && !serial_control.master;
    fall_e    = !transfer_done_flag &&                          // R9
                ((master_on && busy && m_tick && sck_q) ||
                 (slave_on && sck_prev && !pc_sync[2]));
    rise_e    = !transfer_done_flag &&                          // R9
                ((master_on && busy && m_tick && !sck_q) ||
                 (slave_on && !sck_prev && pc_sync[2]));
    done_set  = rise_e && (bit_cnt == ssp_pkg::LAST_BIT);       // R8
    cap_e     = slave_on ? rise_e : rise_pipe[2];               // R19
  end

  // Bus access decode
  always_comb begin
    do_wr     = aw_got && w_got && !s_axi_bvalid;
    rd_go     = s_axi_arvalid && s_axi_arready;
    wr_idx    = word_idx(aw_addr_q);
    rd_idx    = word_idx(s_axi_araddr);
    data_wr   = do_wr && (wr_idx == ssp_pkg::IDX_DATA);
    data_acc  = data_wr || (rd_go && (rd_idx == ssp_pkg::IDX_DATA));
    stat_rd   = rd_go && (rd_idx == ssp_pkg::IDX_STAT);
    clear_seq = armed && transfer_done_flag && data_acc;        // R10
    write_ok  = data_wr && w_lane0_q &&
                (!serial_control.enable ||                      // R16
                 (!busy &&                                      // R13
                  !(transfer_done_flag && !armed)));            // R11
    start_m   = write_ok && master_on;                          // R7
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_control <= '0;                                     // R3 R4 R5 R6
    end else if (do_wr && w_lane0_q && wr_idx == ssp_pkg::IDX_CTRL) begin
      serial_control <= w_data_q & ssp_pkg::CTRL_WMASK;         // R21
    end
  end

  // CPU mask and stop state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_state <= ssp_pkg::CPU_RST;
    end else if (do_wr && w_lane0_q && wr_idx == ssp_pkg::IDX_CPU) begin
      cpu_state <= {6'h00, w_data_q[1:0]};
    end
  end

  // Port C latch and direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_latch         <= '0;
      port_c_direction <= '0;
    end else if (do_wr && w_lane0_q) begin
      if (wr_idx == ssp_pkg::IDX_PORT) begin
        pc_latch <= w_data_q[ssp_pkg::PC_W-1:0];
      end
      if (wr_idx == ssp_pkg::IDX_DIR) begin
        port_c_direction <= w_data_q[ssp_pkg::PC_W-1:0];
      end
    end
  end

  // Transfer done flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transfer_done_flag <= 1'b0;                               // R12
    end else if (done_set) begin
      transfer_done_flag <= 1'b1;                               // R8
    end else if (clear_seq) begin
      transfer_done_flag <= 1'b0;                               // R10
    end
  end

  // Collision flag, never feeds the interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      collision_flag <= 1'b0;                                   // R12
    end else if (serial_control.enable && busy && data_acc) begin
      collision_flag <= 1'b1;                                   // R13 R14
    end else if (clear_seq) begin
      collision_flag <= 1'b0;                                   // R10
    end
  end

  // First step of the clearing sequence
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_control.enable) begin
      armed <= 1'b0;
    end else if (stat_rd && transfer_done_flag) begin
      armed <= 1'b1;                                            // R10 R11
    end else if (data_acc || !transfer_done_flag) begin
      armed <= 1'b0;
    end
  end

  // Bit counter, busy and generated clock
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_control.enable) begin
      busy    <= 1'b0;                                          // R3
      bit_cnt <= 3'h0;
      sck_q   <= 1'b1;
    end else begin
      if (start_m) begin
        busy    <= 1'b1;                                        // R7
        bit_cnt <= 3'h0;
      end else if (rise_e) begin
        bit_cnt <= bit_cnt + 3'h1;
        busy    <= (bit_cnt != ssp_pkg::LAST_BIT);
      end else if (fall_e) begin
        busy <= 1'b1;
      end
      if (master_on && busy && m_tick && !transfer_done_flag) begin
        sck_q <= !sck_q;                                        // R6
      end else if (!master_on) begin
        sck_q <= 1'b1;
      end
    end
  end

  // Master samples wait out the pin round trip; each lands in its bit's place
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_control.enable) begin
      rise_pipe <= 3'h0;
      rx_cnt    <= 3'h0;
    end else begin
      rise_pipe <= {rise_pipe[1:0], rise_e && master_on};
      if (start_m) begin
        rx_cnt <= 3'h0;
      end else if (cap_e) begin
        rx_cnt <= rx_cnt + 3'h1;
      end
    end
  end

  // Shift register and data storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_data_shift <= 8'h00;
    end else if (write_ok) begin
      serial_data_shift <= w_data_q;                            // R16
    end else if (cap_e) begin
      serial_data_shift[bit_pos(rx_cnt, serial_control.lsb_first)] <= // R20 R15 R4
        pc_sync[0];                                             // R19
    end
  end

  // Data out changes on falling clock edge
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_control.enable) begin
      data_out_q <= 1'b1;
    end else if (fall_e) begin
      data_out_q <= serial_data_shift[bit_pos(bit_cnt, serial_control.lsb_first)]; // R19 R4
    end
  end

  // Pin drive and interrupt
  always_comb begin
    if (serial_control.enable) begin
      next_pc_out = {sck_q, data_out_q, pc_latch[0]};           // R17
      next_pc_oe  = {serial_control.master, 1'b1, 1'b0};        // R17 R18
    end else begin
      next_pc_out = pc_latch;                                   // R3
      next_pc_oe  = port_c_direction;
    end
    next_irq = serial_control.irq_en && transfer_done_flag &&   // R1
               !cpu_state.irq_mask &&
               !(cpu_state.stop && serial_control.master);      // R2
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_out       <= '0;
      pc_oe        <= '0;
      transfer_irq <= 1'b0;
    end else begin
      pc_out       <= next_pc_out;
      pc_oe        <= next_pc_oe;
      transfer_irq <= next_irq;
    end
  end

  // Read view
  always_comb begin
    stat_view           = '0;
    stat_view.done      = transfer_done_flag;                   // R21
    stat_view.collision = collision_flag;
    port_view           = 8'h00;
    for (int i = 0; i < ssp_pkg::PC_W; i++) begin
      port_view[i] = port_c_direction[i] ? pc_latch[i] : pc_sync[i]; // R18
    end
    next_rresp = ssp_pkg::RESP_OKAY;
    unique case (rd_idx)
      ssp_pkg::IDX_CTRL: next_rdata = {24'h00_0000, serial_control};
      ssp_pkg::IDX_STAT: next_rdata = {24'h00_0000, stat_view};
      ssp_pkg::IDX_DATA: next_rdata = {24'h00_0000, serial_data_shift};
      ssp_pkg::IDX_CPU:  next_rdata = {24'h00_0000, cpu_state};
      ssp_pkg::IDX_PORT: next_rdata = {24'h00_0000, port_view};
      ssp_pkg::IDX_DIR:  next_rdata = {29'h0000_0000, port_c_direction};
      default: begin
        next_rdata = 32'h0000_0000;
        next_rresp = ssp_pkg::RESP_ERR;
      end
    endcase
    unique case (wr_idx)
      ssp_pkg::IDX_CTRL, ssp_pkg::IDX_STAT, ssp_pkg::IDX_DATA,
      ssp_pkg::IDX_CPU, ssp_pkg::IDX_PORT, ssp_pkg::IDX_DIR: begin
        next_bresp = ssp_pkg::RESP_OKAY;
      end
      default: next_bresp = ssp_pkg::RESP_ERR;
    endcase
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b0;
      aw_addr_q     <= '0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_got &&
                       !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got    <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got <= 1'b0;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane0_q    <= 1'b0;
    end else begin
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_got &&
                      !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_got     <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_got <= 1'b0;
      end
    end
  end

  // Write response channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssp_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= next_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ssp_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: hdl/ssp_rate_div.sv */
// Bit clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none
module ssp_rate_div #(
  parameter int unsigned FAST_HALF = ssp_pkg::FAST_DIV / 2,
  parameter int unsigned SLOW_HALF = ssp_pkg::SLOW_DIV / 2
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic run,
  input  wire logic slow,
  // Half-period pulse
  output logic      tick
);

  if (FAST_HALF < 1 || SLOW_HALF < 1 || SLOW_HALF > 255) begin : g_chk
    $error("ssp_rate_div: half periods must be 1 to 255");
  end

  logic [7:0] cnt;
  logic [7:0] half_m1;

  always_comb begin
    half_m1 = slow ? 8'(SLOW_HALF - 1) : 8'(FAST_HALF - 1); // R6
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == half_m1) begin
      cnt  <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire
